// ### rtl/wdt_wake_pkg.sv
// Package with register map, field layout, reset values and timing counts for the watchdog and wake-up block.
package wdt_wake_pkg;

   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [7:0] ADDR_WDT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SYS_CTRL = 8'h04;
   localparam logic [7:0] ADDR_PA_WAKE = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;

   // Watchdog control layout and reset value.
   localparam int KEY_LSB = 3;
   localparam int KEY_MSB = 7;
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 2;
   localparam logic [7:0] WDT_CTRL_RESET = 8'h53;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [4:0] KEY_ENABLE = 5'h0A;

   // System control flag positions and reset value.
   localparam int SC_KEEP = 7;
   localparam int SC_BROWNOUT = 2;
   localparam int SC_BROWNOUT_CFG = 1;
   localparam int SC_KEY_RESET = 0;
   localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
   localparam logic [7:0] PA_WAKE_RESET = 8'h00;

   // Status register bit positions.
   localparam int ST_POWER_DOWN = 0;
   localparam int ST_EXPIRY = 1;
   localparam int ST_FAST_READY = 2;
   localparam int ST_SLOW_READY = 3;
   localparam int ST_WDT_ON = 4;
   localparam int ST_KEY_PENDING = 5;

   // Timing counts.
   localparam logic [1:0] KEY_RESET_EDGES = 2'h2;
   localparam logic [15:0] FAST_SETTLE_CYC = 16'h0010;
   localparam logic [15:0] SLOW_SETTLE_CYC = 16'h0080;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Watchdog count width covers the longest period.
   localparam int CNT_W = 19;

   // Time-out length in sub clock cycles for each period code.
   function automatic logic [CNT_W-1:0] period_cycles(input logic [2:0] sel);
      logic [CNT_W-1:0] p;
      p = 19'h0_0100;
      unique case (sel)
         3'h0: p = 19'h0_0100;
         3'h1: p = 19'h0_0400;
         3'h2: p = 19'h0_1000;
         3'h3: p = 19'h0_4000;
         3'h4: p = 19'h0_8000;
         3'h5: p = 19'h1_0000;
         3'h6: p = 19'h2_0000;
         3'h7: p = 19'h4_0000;
      endcase
      return p;
   endfunction

   // A key is legal only when it is one of the two defined codes.
   function automatic logic key_legal(input logic [4:0] key);
      return (key == KEY_ENABLE) || (key == KEY_DISABLE);
   endfunction

endpackage

// ### rtl/wdt_counter.sv
// Watchdog counter that counts sub clock ticks and flags the selected overflow.
`timescale 1ns/100ps
`default_nettype none
module wdt_counter
   import wdt_wake_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Control.
   input wire logic run,
   input wire logic tick,
   input wire logic clear,
   input wire logic [2:0] period_select,
   // Result.
   output logic overflow,
   output logic [CNT_W-1:0] count
);

   logic [CNT_W-1:0] count_reg;
   logic overflow_reg;
   logic [CNT_W-1:0] limit;

   assign limit = period_cycles(period_select);
   assign count = count_reg;
   assign overflow = overflow_reg;

   // Count ticks from zero, restart on clear or on reaching the period.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_reg <= '0;
         overflow_reg <= 1'b0;
      end
      else if (clear)
      begin
         count_reg <= '0;
         overflow_reg <= 1'b0;
      end
      else if (run && tick)
      begin
         if (count_reg == limit - 19'h0_0001)
         begin
            count_reg <= '0;
            overflow_reg <= 1'b1;
         end
         else
         begin
            count_reg <= count_reg + 19'h0_0001;
            overflow_reg <= 1'b0;
         end
      end
      else
      begin
         overflow_reg <= 1'b0;
      end
   end

   // Overflow marks exactly the tick that ends the chosen period.
   overflow_at_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      run && tick && !clear && count_reg == limit - 19'h0_0001 |=> overflow_reg && count_reg == '0)
      else $error("watchdog overflow missing at period end");

endmodule
`default_nettype wire

// ### rtl/watchdog_and_wakeup_control.sv
// Watchdog with keyed enable, power-down wake-up logic and shared oscillator settling.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module watchdog_and_wakeup_control
   import wdt_wake_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Pins and oscillator clocks sampled as data.
   input wire logic sub_clock_pin,
   input wire logic slow_rc_pin,
   input wire logic [7:0] porta_pin,
   input wire logic slow_xtal_sel,
   // CPU events on this clock.
   input wire logic halt_exec,
   input wire logic clear_watchdog_instr_exec,
   input wire logic [7:0] irq_pending,
   input wire logic [7:0] irq_enabled,
   input wire logic stack_full,
   // Results to the core.
   output logic device_reset_req,
   output logic pc_sp_reset,
   output logic resume_after_halt,
   output logic take_interrupt,
   output logic cpu_run,
   output logic power_down,
   output logic sub_clock_enable
);

   typedef enum logic [1:0] {RUNNING, SLEEPING, SETTLING} pm_state_t;
   typedef enum logic [1:0] {WK_PORT, WK_IRQ_RESUME, WK_IRQ_TAKE, WK_WDT} wake_kind_t;
   typedef enum logic [1:0] {SET_IDLE, SET_FAST, SET_SLOW} settle_phase_t;

   localparam int NSYNC = 10;

   pm_state_t state_reg;
   wake_kind_t kind_reg;
   wake_kind_t kind_now;
   settle_phase_t phase_reg;
   logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, stable_reg, prev_reg;
   logic [NSYNC-1:0] rise, fall;
   logic [7:0] wdt_ctrl_reg, sys_ctrl_reg, pa_wake_reg, irq_mask_reg;
   logic pdf_reg, to_reg, deep_reg, fast_ready_reg, slow_ready_reg;
   logic key_viol_reg, key_fire;
   logic [1:0] viol_cnt_reg;
   logic [15:0] settle_cnt_reg;
   logic wdt_on, wdt_ovf, wdt_clear, halt_now, wake_now, fire;
   logic [7:0] pa_wake_hit, irq_new;
   logic aw_held_reg, w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic do_write;
   logic [31:0] rd_word;

   // Each outside input passes three flops; a change counts once stages two and three agree.
   genvar g;
   generate
      for (g = 0; g < NSYNC; g++)
      begin : g_sync
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               s1_reg[g] <= 1'b1;
               s2_reg[g] <= 1'b1;
               s3_reg[g] <= 1'b1;
               stable_reg[g] <= 1'b1;
               prev_reg[g] <= 1'b1;
            end
            else
            begin
               s1_reg[g] <= (g < 8) ? porta_pin[g % 8] : ((g == 8) ? sub_clock_pin : slow_rc_pin);
               s2_reg[g] <= s1_reg[g];
               s3_reg[g] <= s2_reg[g];
               if (s2_reg[g] == s3_reg[g])
               begin
                  stable_reg[g] <= s3_reg[g];
               end
               prev_reg[g] <= stable_reg[g];
            end
         end
         assign rise[g] = stable_reg[g] & ~prev_reg[g];
         assign fall[g] = ~stable_reg[g] & prev_reg[g];
      end
   endgenerate

   // Watchdog state decoded from the key field.
   assign wdt_on = (wdt_ctrl_reg[KEY_MSB:KEY_LSB] == KEY_ENABLE);
   assign halt_now = (state_reg == RUNNING) && halt_exec;
   assign wdt_clear = clear_watchdog_instr_exec || halt_now || key_fire;

   // The watchdog counts sub clock rising edges only while enabled.
   wdt_counter u_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(wdt_on),
      .tick(rise[8]),
      .clear(wdt_clear),
      .period_select(wdt_ctrl_reg[SEL_MSB:SEL_LSB]),
      .overflow(wdt_ovf),
      .count()
   );

   // Wake sources and the kind of restart each one asks for.
   assign pa_wake_hit = fall[7:0] & pa_wake_reg;
   assign irq_new = irq_pending & ~irq_mask_reg;
   assign wake_now = (state_reg == SLEEPING) && ((|pa_wake_hit) || (|irq_new) || wdt_ovf);
   always_comb
   begin
      kind_now = WK_PORT;
      if (wdt_ovf)
         kind_now = WK_WDT;
      else if (|irq_new)
         kind_now = ((|(irq_new & irq_enabled)) && !stack_full) ? WK_IRQ_TAKE : WK_IRQ_RESUME;
   end
   assign fire = (wake_now && !deep_reg) || ((state_reg == SETTLING) && fast_ready_reg);

   // Power management sequence: halt, sleep, optional settling, run.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= RUNNING;
         kind_reg <= WK_PORT;
         deep_reg <= 1'b0;
         irq_mask_reg <= 8'h00;
      end
      else
      begin
         unique case (state_reg)
            RUNNING:
               if (halt_exec)
               begin
                  state_reg <= SLEEPING;
                  deep_reg <= !wdt_on;
                  irq_mask_reg <= irq_pending;
               end
            SLEEPING:
               if (wake_now)
               begin
                  kind_reg <= kind_now;
                  state_reg <= deep_reg ? SETTLING : RUNNING;
               end
            SETTLING:
               if (fast_ready_reg)
                  state_reg <= RUNNING;
         endcase
      end
   end

   // Restart pulses to the core, one cycle each.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pc_sp_reset <= 1'b0;
         resume_after_halt <= 1'b0;
         take_interrupt <= 1'b0;
      end
      else
      begin
         pc_sp_reset <= fire && ((state_reg == SLEEPING ? kind_now : kind_reg) == WK_WDT);
         resume_after_halt <= fire && ((state_reg == SLEEPING ? kind_now : kind_reg) inside {WK_PORT, WK_IRQ_RESUME});
         take_interrupt <= fire && ((state_reg == SLEEPING ? kind_now : kind_reg) == WK_IRQ_TAKE);
      end
   end

   // Core run and power-down indications.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_run <= 1'b1;
         power_down <= 1'b0;
         sub_clock_enable <= 1'b1;
      end
      else
      begin
         cpu_run <= (state_reg == RUNNING && !halt_exec) || fire;
         power_down <= (state_reg == RUNNING) ? halt_exec : !fire;
         sub_clock_enable <= wdt_on;
      end
   end

   // Power down and expiry flags.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pdf_reg <= 1'b0;
         to_reg <= 1'b0;
      end
      else
      begin
         if (halt_now)
            pdf_reg <= 1'b1;
         else if (clear_watchdog_instr_exec)
            pdf_reg <= 1'b0;
         if (wdt_ovf)
            to_reg <= 1'b1;
         else if (halt_now)
            to_reg <= 1'b0;
      end
   end

   // Time-out while running asks for a full device reset.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         device_reset_req <= 1'b0;
      else
         device_reset_req <= key_fire || (wdt_ovf && state_reg == RUNNING);
   end

   // Illegal key: count slow RC edges, then reset after the second one.
   assign key_fire = key_viol_reg && rise[9] && (viol_cnt_reg == KEY_RESET_EDGES - 2'h1);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         key_viol_reg <= 1'b0;
         viol_cnt_reg <= 2'h0;
      end
      else if (do_write && aw_addr_reg == ADDR_WDT_CTRL && !key_legal(w_data_reg[KEY_MSB:KEY_LSB]))
      begin
         key_viol_reg <= 1'b1;
         viol_cnt_reg <= 2'h0;
      end
      else if (key_fire)
      begin
         key_viol_reg <= 1'b0;
         viol_cnt_reg <= 2'h0;
      end
      else if (key_viol_reg && rise[9])
         viol_cnt_reg <= viol_cnt_reg + 2'h1;
   end

   // Shared settle counter: fast oscillator first, slow crystal afterwards.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phase_reg <= SET_IDLE;
         settle_cnt_reg <= 16'h0000;
         fast_ready_reg <= 1'b1;
         slow_ready_reg <= 1'b1;
      end
      else if (halt_now && !wdt_on)
      begin
         fast_ready_reg <= 1'b0;
         slow_ready_reg <= !slow_xtal_sel;
         phase_reg <= SET_IDLE;
      end
      else if (wake_now && deep_reg)
      begin
         phase_reg <= SET_FAST;
         settle_cnt_reg <= 16'h0000;
      end
      else
      begin
         unique case (phase_reg)
            SET_IDLE: settle_cnt_reg <= 16'h0000;
            SET_FAST:
               if (settle_cnt_reg == FAST_SETTLE_CYC - 16'h0001)
               begin
                  fast_ready_reg <= 1'b1;
                  settle_cnt_reg <= 16'h0000;
                  phase_reg <= slow_ready_reg ? SET_IDLE : SET_SLOW;
               end
               else
                  settle_cnt_reg <= settle_cnt_reg + 16'h0001;
            SET_SLOW:
               if (settle_cnt_reg == SLOW_SETTLE_CYC - 16'h0001)
               begin
                  slow_ready_reg <= 1'b1;
                  phase_reg <= SET_IDLE;
               end
               else
                  settle_cnt_reg <= settle_cnt_reg + 16'h0001;
            default: phase_reg <= SET_IDLE;
         endcase
      end
   end

   // AXI write address and data are taken in either order, one write at a time.
   assign do_write = aw_held_reg && w_held_reg && !bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else
      begin
         awready <= !aw_held_reg && !awready && awvalid;
         wready <= !w_held_reg && !wready && wvalid;
         if (awvalid && awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (do_write)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (aw_addr_reg inside {ADDR_WDT_CTRL, ADDR_SYS_CTRL, ADDR_PA_WAKE, ADDR_STATUS}) ?
                     RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Software-writable registers; hardware events win over software writes.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_ctrl_reg <= WDT_CTRL_RESET;
         sys_ctrl_reg <= SYS_CTRL_RESET;
         pa_wake_reg <= PA_WAKE_RESET;
      end
      else
      begin
         if (key_fire)
            wdt_ctrl_reg <= WDT_CTRL_RESET;
         else if (do_write && aw_addr_reg == ADDR_WDT_CTRL && w_strb_reg[0])
            wdt_ctrl_reg <= w_data_reg[7:0];
         if (do_write && aw_addr_reg == ADDR_PA_WAKE && w_strb_reg[0])
            pa_wake_reg <= w_data_reg[7:0];
         if (do_write && aw_addr_reg == ADDR_SYS_CTRL && w_strb_reg[0])
         begin
            sys_ctrl_reg[SC_KEEP] <= w_data_reg[SC_KEEP];
            sys_ctrl_reg[SC_BROWNOUT] <= w_data_reg[SC_BROWNOUT];
            sys_ctrl_reg[SC_BROWNOUT_CFG] <= w_data_reg[SC_BROWNOUT_CFG];
            if (!w_data_reg[SC_KEY_RESET])
               sys_ctrl_reg[SC_KEY_RESET] <= 1'b0;
         end
         if (key_fire)
            sys_ctrl_reg[SC_KEY_RESET] <= 1'b1;
      end
   end

   // Read word for the requested address; unused bits read as zero.
   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         ADDR_WDT_CTRL: v[7:0] = wdt_ctrl_reg;
         ADDR_SYS_CTRL: v[7:0] = {sys_ctrl_reg[SC_KEEP], 4'h0, sys_ctrl_reg[2:0]};
         ADDR_PA_WAKE: v[7:0] = pa_wake_reg;
         ADDR_STATUS: v[5:0] = {key_viol_reg, wdt_on, slow_ready_reg, fast_ready_reg, to_reg, pdf_reg};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction
   // A process, not an assign, so the word follows register changes while the address stays put.
   always_comb
   begin
      rd_word = read_word(araddr);
   end

   // AXI read: address taken, data one cycle later, held until rready.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end
      else
      begin
         arready <= !arready && !rvalid && arvalid;
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= (araddr inside {ADDR_WDT_CTRL, ADDR_SYS_CTRL, ADDR_PA_WAKE, ADDR_STATUS}) ?
                     RESP_OKAY : RESP_SLVERR;
         end
         else if (rvalid && rready)
            rvalid <= 1'b0;
      end
   end

   // Checks on the wake-up and watchdog behaviour.
   halt_sets_pdf_a: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_now |=> pdf_reg && state_reg == SLEEPING && power_down)
      else $error("halt did not set power down flag");
   clr_clears_pdf_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clear_watchdog_instr_exec && !halt_now |=> !pdf_reg)
      else $error("clear instruction left power down flag set");
   sleep_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == SLEEPING && wdt_ovf && !deep_reg |=> to_reg && pc_sp_reset && !device_reset_req)
      else $error("time-out in sleep did not wake with PC and SP reset");
   run_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == RUNNING && wdt_ovf |=> device_reset_req && to_reg)
      else $error("time-out while running did not reset device");
   port_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == SLEEPING && !deep_reg && (|pa_wake_hit) && !wdt_ovf && !(|irq_new)
      |=> state_reg == RUNNING && resume_after_halt)
      else $error("Port A wake did not resume after halt");
   old_irq_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == SLEEPING && !(|irq_new) && !(|pa_wake_hit) && !wdt_ovf |=> state_reg == SLEEPING)
      else $error("device woke without a fresh wake source");
   settle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == SETTLING && !fast_ready_reg |=> !cpu_run)
      else $error("core ran before fast oscillator was ready");
   key_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      key_viol_reg && rise[9] && viol_cnt_reg == 2'h1 |=> device_reset_req && sys_ctrl_reg[SC_KEY_RESET])
      else $error("key violation did not reset on second slow RC edge");
   key_flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sys_ctrl_reg[SC_KEY_RESET] && !(do_write && aw_addr_reg == ADDR_SYS_CTRL) |=> sys_ctrl_reg[SC_KEY_RESET])
      else $error("key reset flag cleared without software");
   reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready && araddr == ADDR_SYS_CTRL |=> rdata[6:3] == 4'h0)
      else $error("reserved control bits read nonzero");

endmodule
`default_nettype wire

// ### verification/watchdog_and_wakeup_control_test.sv
// Self-checking bench for the watchdog and wake-up block.
`timescale 1ns/100ps
`default_nettype none
module watchdog_and_wakeup_control_test;
   import wdt_wake_pkg::*;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic [1:0] r;} row_t;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, porta_pin, irq_pending, irq_enabled;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r, ph;
   logic sub_clock_pin, slow_rc_pin, slow_xtal_sel, halt_exec, clear_watchdog_instr_exec, stack_full, sub_run;
   logic device_reset_req, pc_sp_reset, resume_after_halt, take_interrupt, cpu_run, power_down, sub_clock_enable;
   int err_count, n_compared, sub_edges, rc_edges, s0, i;
   row_t rows [5] = '{'{8'h04, 8'hFF, 8'h86, RESP_OKAY}, '{8'h08, 8'hA5, 8'hA5, RESP_OKAY},
      '{8'h00, 8'hAB, 8'hAB, RESP_OKAY}, '{8'h10, 8'hFF, 8'h00, RESP_SLVERR}, '{8'h00, 8'h50, 8'h50, RESP_OKAY}};
   watchdog_and_wakeup_control watchdog_and_wakeup_control_inst (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sub_clock_pin(sub_clock_pin), .slow_rc_pin(slow_rc_pin), .porta_pin(porta_pin),
      .slow_xtal_sel(slow_xtal_sel), .halt_exec(halt_exec), .clear_watchdog_instr_exec(clear_watchdog_instr_exec),
      .irq_pending(irq_pending), .irq_enabled(irq_enabled), .stack_full(stack_full),
      .device_reset_req(device_reset_req), .pc_sp_reset(pc_sp_reset), .resume_after_halt(resume_after_halt),
      .take_interrupt(take_interrupt), .cpu_run(cpu_run), .power_down(power_down),
      .sub_clock_enable(sub_clock_enable));
   // Clock of 25 ns period.
   initial
   begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   // Slow oscillators as data: sub clock toggles every 2 cycles when enabled, slow RC every 4.
   always @(posedge aclk)
   begin
      ph <= ph + 2'h1;
      if (sub_run && ph[0])
      begin
         sub_clock_pin <= ~sub_clock_pin;
         sub_edges <= sub_edges + !sub_clock_pin;
      end
      if (ph == 2'h3)
      begin
         slow_rc_pin <= ~slow_rc_pin;
         rc_edges <= rc_edges + !slow_rc_pin;
      end
   end
   // Verdict and end of run.
   task results;
      if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Compare one value with its expectation.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Pick a result output by number.
   function logic pick(input int k);
      case (k)
         0: return device_reset_req;
         1: return pc_sp_reset;
         2: return resume_after_halt;
         3: return take_interrupt;
         default: return power_down;
      endcase
   endfunction
   // Wait for an output under a bound; running out ends the run.
   task waitsig(input int k, input int lim);
      int n;
      for (n = 0; n < lim && pick(k) !== 1'b1; n++) @(posedge aclk);
      if (n == lim)
      begin
         chk(k, 32'hFFFF);
         results();
      end
   endtask
   // Bus write: address and data offered together, each released when taken.
   task wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      awaddr <= a; wdata <= {24'h00_0000, v}; wstrb <= 4'h1; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      r = bresp; bready <= 0;
      if (n == 50)
      begin
         err_count++;
         results();
      end
   endtask
   // Bus read.
   task rd(input logic [7:0] a);
      int n;
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      d = rdata; r = rresp; rready <= 0;
      if (n == 50)
      begin
         err_count++;
         results();
      end
   endtask
   // One-cycle core event pulses.
   task halt;
      halt_exec <= 1; @(posedge aclk); halt_exec <= 0; waitsig(4, 5);
   endtask
   task clr;
      clear_watchdog_instr_exec <= 1; @(posedge aclk); clear_watchdog_instr_exec <= 0;
   endtask
   // Main sequence.
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, halt_exec, clear_watchdog_instr_exec, stack_full, sub_run} = 0;
      {awaddr, araddr, wdata, wstrb, irq_pending, irq_enabled, ph, slow_xtal_sel} = 0;
      {sub_clock_pin, slow_rc_pin, sub_edges, rc_edges, err_count, n_compared} = 0;
      porta_pin = 8'hFF; aresetn = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1; @(posedge aclk);
      rd(ADDR_WDT_CTRL); chk(d, 32'h0000_0053); chk(sub_clock_enable, 1);
      rd(ADDR_SYS_CTRL); chk(d, 32'h0000_0000);
      foreach (rows[k])
      begin
         wr(rows[k].a, rows[k].d); chk(r, rows[k].r);
         rd(rows[k].a); chk(d, {24'h00_0000, rows[k].q}); chk(r, rows[k].r);
         if (k == 2 || k == 4) chk(sub_clock_enable, rows[k].d[7:3] == KEY_ENABLE);
      end
      clr(); s0 = sub_edges; sub_run <= 1; waitsig(0, 2000);
      chk(sub_edges - s0 >= 256 && sub_edges - s0 <= 257, 1); sub_run <= 0;
      rd(ADDR_STATUS); chk(d[ST_EXPIRY], 1);
      irq_enabled <= 8'hFF; irq_pending <= 8'h02; halt();
      rd(ADDR_STATUS); chk(d[1:0], 2'h1);
      repeat (20) @(posedge aclk) chk(take_interrupt | resume_after_halt, 0);
      irq_pending <= 8'h03; waitsig(3, 12); @(posedge aclk); chk(cpu_run, 1);
      irq_pending <= 0; clr(); rd(ADDR_STATUS); chk(d[ST_POWER_DOWN], 0);
      stack_full <= 1; halt(); irq_pending <= 8'h01; waitsig(2, 12);
      irq_pending <= 0; stack_full <= 0; halt(); porta_pin <= 8'hFD;
      repeat (12) @(posedge aclk) chk(resume_after_halt, 0);
      porta_pin <= 8'hFC; waitsig(2, 12); porta_pin <= 8'hFF;
      halt(); sub_run <= 1; waitsig(1, 2000); sub_run <= 0;
      rd(ADDR_STATUS); chk(d[ST_EXPIRY], 1);
      wr(ADDR_WDT_CTRL, 8'hA8); slow_xtal_sel <= 1; halt(); irq_pending <= 8'h04;
      repeat (10) @(posedge aclk) chk(cpu_run, 0);
      chk(sub_clock_enable, 0);
      waitsig(3, 20); rd(ADDR_STATUS); chk(d[3:2], 2'h1);
      repeat (130) @(posedge aclk); rd(ADDR_STATUS); chk(d[3:2], 2'h3); irq_pending <= 0;
      wr(ADDR_WDT_CTRL, 8'h00); s0 = rc_edges; waitsig(0, 100);
      chk(rc_edges - s0 >= 1 && rc_edges - s0 <= 2, 1);
      rd(ADDR_SYS_CTRL); chk(d[SC_KEY_RESET], 1);
      wr(ADDR_SYS_CTRL, 8'h00); rd(ADDR_SYS_CTRL); chk(d, 32'h0000_0000);
      results();
   end
endmodule
`default_nettype wire
